// ==== gpio_port_pkg.sv ====
/*
 * Shared types and constants for the general-purpose I/O port.
 * Assumes a single system clock and an active-low asynchronous reset.
 */
package gpio_port_pkg;

    // ************************************************************
    // Sizes and codes
    // ************************************************************
    localparam int   PORT_WIDTH      = 8;
    localparam int   DRIVE_MODE_W    = 3;
    localparam int   ROUTE_SEL_W     = 2;

    typedef enum logic [2:0] {
        DM_ANALOG     = 3'h0,
        DM_INPUT_ONLY = 3'h1,
        DM_PULLUP     = 3'h2,
        DM_PULLDOWN   = 3'h3,
        DM_OD_LOW     = 3'h4,
        DM_OD_HIGH    = 3'h5,
        DM_STRONG     = 3'h6,
        DM_WEAK       = 3'h7
    } drive_mode_t;

    localparam logic [1:0] ROUTE_PORT    = 2'h0;
    localparam logic [1:0] ROUTE_PERIPH0 = 2'h1;
    localparam logic [1:0] ROUTE_PERIPH1 = 2'h2;
    localparam logic [1:0] ROUTE_ANALOG  = 2'h3;

    // Edge select codes for the pin interrupts.
    localparam logic [1:0] EDGE_NONE     = 2'h0;
    localparam logic [1:0] EDGE_RISE     = 2'h1;
    localparam logic [1:0] EDGE_FALL     = 2'h2;
    localparam logic [1:0] EDGE_BOTH     = 2'h3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] OUT_DATA_RST  = 8'h00;
    localparam logic [7:0] FLAG_RST      = 8'h00;

    // Drive signals presented to one pad.
    typedef struct packed {
        logic out;
        logic strong_hi;
        logic strong_lo;
        logic weak_hi;
        logic weak_lo;
        logic in_en;
        logic lvttl;
        logic slow_slew;
        logic analog_en;
    } pad_ctl_t;

endpackage

// ==== general_purpose_io_port.sv ====
/*
 * One general-purpose I/O port of up to eight pins: drive modes, threshold and slew
 * selection, hold latch, signal routing, output and pin-state stores, pin interrupts.
 * Assumes pad cells that take the per-pin controls; pin inputs are asynchronous.
 */

module general_purpose_io_port
    import gpio_port_pkg::*;
#(
    parameter int N = PORT_WIDTH
) (
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire logic [N-1:0][2:0]           drive_mode,
    input  wire logic [N-1:0]                lvttl_sel,
    input  wire logic [N-1:0]                slow_slew,
    input  wire logic [N-1:0][1:0]           io_signal_matrix,
    input  wire logic [N-1:0]                periph0_out,
    input  wire logic [N-1:0]                periph1_out,
    input  wire logic                        hold,
    input  wire logic                        out_wr,
    input  wire logic [N-1:0]                out_wdata,
    input  wire logic [N-1:0][1:0]           irq_edge,
    input  wire logic [N-1:0]                irq_en,
    input  wire logic [N-1:0]                flag_clr,
    input  wire logic [N-1:0]                pin_in,
    output logic      [N-1:0]                pin_state,
    output logic      [N-1:0]                out_data,
    output logic      [N-1:0]                irq_flags,
    output logic                             port_irq,
    output pad_ctl_t  [N-1:0]                pad_ctl
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic     [N-1:0] sync1;
        logic     [N-1:0] sync2;
        logic     [N-1:0] state;
        logic     [N-1:0] prev;
        logic     [N-1:0] dout;
        logic     [N-1:0] flags;
        logic             irq;
        pad_ctl_t [N-1:0] pad;
    } st_t;

    st_t st_r;
    st_t st_nxt;

    function automatic pad_ctl_t pad_of(logic [2:0] m, logic d, logic lv, logic sl, logic an);
        pad_ctl_t p;
        p = '0;
        p.out       = d;
        p.lvttl     = lv;
        p.slow_slew = sl;
        p.in_en     = (m != DM_ANALOG) && !an;
        p.analog_en = (m == DM_ANALOG) || an;
        // A single data bit picks which side of the pad is on.
        unique case (drive_mode_t'(m))
            DM_ANALOG:     ;
            DM_INPUT_ONLY: ;
            DM_PULLUP:     begin p.weak_hi = d;  p.strong_lo = !d; end
            DM_PULLDOWN:   begin p.strong_hi = d; p.weak_lo = !d;  end
            DM_OD_LOW:     p.strong_lo = !d;
            DM_OD_HIGH:    p.strong_hi = d;
            DM_STRONG:     begin p.strong_hi = d; p.strong_lo = !d; end
            DM_WEAK:       begin p.weak_hi = d;   p.weak_lo = !d;   end
        endcase
        if (an) begin
            p.strong_hi = 1'b0;
            p.strong_lo = 1'b0;
            p.weak_hi   = 1'b0;
            p.weak_lo   = 1'b0;
        end
        return p;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [N-1:0] edge_hit;
        logic         d;
        st_nxt   = st_r;
        edge_hit = '0;
        d        = 1'b0;
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.state = st_r.sync2;
        st_nxt.prev  = st_r.state;
        if (out_wr) begin
            st_nxt.dout = out_wdata;
        end
        for (int i = 0; i < N; i++) begin
            unique case (irq_edge[i])
                EDGE_NONE: edge_hit[i] = 1'b0;
                EDGE_RISE: edge_hit[i] = st_r.state[i] & ~st_r.prev[i];
                EDGE_FALL: edge_hit[i] = ~st_r.state[i] & st_r.prev[i];
                EDGE_BOTH: edge_hit[i] = st_r.state[i] ^ st_r.prev[i];
            endcase
            unique case (io_signal_matrix[i])
                ROUTE_PORT:    d = st_nxt.dout[i];
                ROUTE_PERIPH0: d = periph0_out[i];
                ROUTE_PERIPH1: d = periph1_out[i];
                ROUTE_ANALOG:  d = 1'b0;
            endcase
            // Hold keeps the last pad controls so the pin survives deep power-down.
            if (!hold) begin
                st_nxt.pad[i] = pad_of(drive_mode[i], d, lvttl_sel[i], slow_slew[i],
                                       io_signal_matrix[i] == ROUTE_ANALOG);
            end
        end
        // Clear then set so a fresh edge in the clear cycle is kept.
        st_nxt.flags = (st_r.flags & ~flag_clr) | (edge_hit & irq_en);
        st_nxt.irq   = |(st_nxt.flags & irq_en);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r       <= '0;
            st_r.dout  <= OUT_DATA_RST;
            st_r.flags <= FLAG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_state = st_r.state;
    assign out_data  = st_r.dout;
    assign irq_flags = st_r.flags;
    assign port_irq  = st_r.irq;
    assign pad_ctl   = st_r.pad;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_irq_follows_flags: assert property (
        ##1 port_irq == |($past(st_nxt.flags) & $past(irq_en)))
        else $error("port request does not match enabled flags");
    a_flag_sticky: assert property (
        irq_flags[0] && !flag_clr[0] |=> irq_flags[0])
        else $error("pin flag dropped without a clear");
    a_flag_set_wins: assert property (
        flag_clr[0] && irq_en[0] && irq_edge[0] == EDGE_BOTH
        && (pin_state[0] != st_r.prev[0]) |=> irq_flags[0])
        else $error("edge lost in clear cycle");
    a_hold_freezes: assert property (
        hold && $past(hold) |-> $stable(pad_ctl))
        else $error("pad controls changed during hold");
    a_out_store: assert property (
        out_wr |=> out_data == $past(out_wdata))
        else $error("output store not written");
    a_pin_sync: assert property (
        ##3 pin_state == $past(pin_in, 3))
        else $error("pin state not three cycles behind pin");
    a_analog_off: assert property (
        !hold && drive_mode[0] == DM_ANALOG |=> !pad_ctl[0].in_en
        && !pad_ctl[0].strong_hi && !pad_ctl[0].strong_lo)
        else $error("analog mode leaves a buffer on");
    a_strong_drive: assert property (
        !hold && drive_mode[0] == DM_STRONG && io_signal_matrix[0] == ROUTE_PERIPH0
        |=> pad_ctl[0].out == $past(periph0_out[0]))
        else $error("routed peripheral not driven");
    a_threshold: assert property (
        !hold |=> pad_ctl[0].lvttl == $past(lvttl_sel[0])
        && pad_ctl[0].slow_slew == $past(slow_slew[0]))
        else $error("threshold or slew not applied");
    a_reset_analog: assert property (@(posedge mclk)
        $rose(resetn) |-> !pad_ctl[0].in_en && !pad_ctl[0].strong_lo)
        else $error("pin not analog after reset");

    c_irq_raised: cover property (!port_irq ##1 port_irq);
    c_hold_used:  cover property (hold [*3]);
    c_clear:      cover property (irq_flags[0] ##1 flag_clr[0] ##1 !irq_flags[0]);
    c_periph:     cover property (io_signal_matrix[0] == ROUTE_PERIPH1 && !hold);

endmodule

// ==== pin_world.sv ====
/* Model of the circuitry outside the port pins.
 * Assumes pad controls from the port and a driven level chosen by the bench. */
module pin_world
    import gpio_port_pkg::*;
#(
    parameter int N = PORT_WIDTH
) (
    input  wire pad_ctl_t [N-1:0] pad,
    input  wire logic     [N-1:0] ext,
    output logic          [N-1:0] pin
);
    // The outside source is weak: a strong pad driver overrides it.
    // It toggles only as fast as the bench steps it, well inside port limits.
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pin[i] = pad[i].strong_hi ? 1'b1 : pad[i].strong_lo ? 1'b0 : ext[i];
        end
    end
endmodule

// ==== general_purpose_io_port_tb.sv ====
/* Self-checking bench for the I/O port.
 * Assumes the pin model closes the loop from pad controls back to pin inputs. */
module general_purpose_io_port_tb;
    import gpio_port_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int N = PORT_WIDTH;
    logic                  mclk, resetn, hold, out_wr, port_irq;
    logic [N-1:0][2:0]     drive_mode;
    logic [N-1:0][1:0]     io_signal_matrix, irq_edge;
    logic [N-1:0]          lvttl_sel, slow_slew, periph0_out, periph1_out, out_wdata, irq_en;
    logic [N-1:0]          flag_clr, pin_in, ext, pin_state, out_data, irq_flags;
    pad_ctl_t [N-1:0]      pad_ctl;
    pad_ctl_t              p;
    int                    n_fail, total_checks, cyc;

    general_purpose_io_port #(.N(N)) i_dut (.mclk, .resetn, .drive_mode, .lvttl_sel, .slow_slew,
        .io_signal_matrix, .periph0_out, .periph1_out, .hold, .out_wr, .out_wdata, .irq_edge,
        .irq_en, .flag_clr, .pin_in, .pin_state, .out_data, .irq_flags, .port_irq, .pad_ctl);
    pin_world #(.N(N)) i_world (.pad(pad_ctl), .ext(ext), .pin(pin_in));

    // ****************
    // Shared tasks
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // A hang counts as a mismatch.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        {resetn, hold, out_wr, drive_mode, io_signal_matrix, irq_edge, lvttl_sel} = '0;
        {slow_slew, periph0_out, periph1_out, out_wdata, irq_en, flag_clr, ext} = '0;
        step(6);
        chk("pad_in_reset", pad_ctl[0], 16'h0000);
        resetn = 1'b1;
        step(1);
        p = pad_ctl[0];
        chk("pad_after_reset", {p.strong_hi, p.strong_lo, p.weak_hi, p.weak_lo, p.in_en}, 0);
        $display("reset test done");
        // Every drive mode with both output levels, threshold and slew riding along.
        for (int m = 0; m < 8; m++) begin
            for (int o = 0; o < 2; o++) begin
                drive_mode[0] = 3'(m);
                lvttl_sel[0] = o[0];
                slow_slew[0] = ~o[0];
                out_wdata[0] = o[0];
                out_wr = 1'b1;
                step(1);
                out_wr = 1'b0;
                p = pad_ctl[0];
                chk("out_data", out_data[0], o);
                chk("strong_pair", {p.strong_hi, p.strong_lo}, {o[0] & (m == 3 || m == 5 || m == 6),
                    !o[0] & (m == 2 || m == 4 || m == 6)});
                chk("in_en", p.in_en, m != 0);
                chk("lvttl", p.lvttl, o);
                chk("slew", p.slow_slew, !o[0]);
            end
        end
        $display("drive mode test done");
        {periph0_out[0], io_signal_matrix[0]} = {1'b1, ROUTE_PERIPH0};
        step(1);
        chk("route_p0", pad_ctl[0].out, 1);
        io_signal_matrix[0] = ROUTE_PERIPH1;
        step(1);
        chk("route_p1", pad_ctl[0].out, 0);
        io_signal_matrix[0] = ROUTE_ANALOG;
        step(1);
        p = pad_ctl[0];
        chk("route_an", {p.analog_en, p.strong_hi, p.strong_lo, p.in_en}, 16'h0008);
        io_signal_matrix[0] = ROUTE_PORT;
        $display("routing test done");
        // A strong driver is used so that the held level wins over the weak outside source.
        {out_wr, out_wdata[0], drive_mode[0]} = {2'b11, DM_STRONG};
        step(1);
        {out_wr, hold, drive_mode[0]} = {2'b01, DM_ANALOG};
        step(1);
        p = pad_ctl[0];
        step(3);
        chk("hold_pad", pad_ctl[0], p);
        chk("hold_pin", pin_in[0], 1);
        hold = 1'b0;
        step(1);
        chk("unhold", pad_ctl[0].strong_hi, 0);
        $display("hold test done");
        {drive_mode[0], irq_edge[0], irq_en[0]} = {DM_INPUT_ONLY, EDGE_RISE, 1'b1};
        step(4);
        ext[0] = 1'b1;
        step(3);
        chk("pin_state", pin_state[0], 1);
        chk("flag_early", irq_flags[0], 0);
        step(1);
        chk("flag_set", irq_flags[0], 1);
        chk("port_irq", port_irq, 1);
        ext[0] = 1'b0;
        step(5);
        chk("flag_sticky", irq_flags[0], 1);
        flag_clr[0] = 1'b1;
        step(1);
        flag_clr[0] = 1'b0;
        chk("flag_clr", {irq_flags[0], port_irq}, 0);
        {irq_en[0], ext[0]} = 2'b01;
        step(5);
        chk("flag_masked", {irq_flags[0], port_irq}, 0);
        {irq_edge[0], irq_en[0], ext[0]} = {EDGE_FALL, 2'b10};
        step(4);
        chk("flag_fall", irq_flags[0], 1);
        // The clear lands on the same edge as a fresh rising edge: the set must win.
        {irq_edge[0], ext[0]} = {EDGE_BOTH, 1'b1};
        step(3);
        flag_clr[0] = 1'b1;
        step(1);
        flag_clr[0] = 1'b0;
        chk("flag_set_wins", {irq_flags[0], port_irq}, 16'h0003);
        $display("interrupt test done");
        wrap_up();
    end
endmodule
